// File: dcpwm_bus_master.sv
// Purpose: byte wide classic wishbone master standing in for the cpu
// Assumes: single clock; after the blocking idle values at time zero, every signal changes by non-blocking assignment after a rising edge
// Notes:   busOp holds the request until ack is sampled high or 16 edges pass without it, then releases it

`timescale 1ns/1ns

module dcpwm_bus_master
  import dcpwm_pkg::*;
(
  // clock
  input  wire logic             clk,
  // wishbone master side
  output logic                  cyc,
  output logic                  stb,
  output logic                  we,
  output logic      [ADR_W-1:0] adr,
  output logic      [0:0]       sel,
  output logic      [BUS_W-1:0] dat,
  input  wire logic [BUS_W-1:0] datIn,
  input  wire logic             ack
);
  // idle bus from time zero
  initial begin
    {cyc, stb, we, sel} = 4'h0;
    adr = '0;
    dat = '0;
  end

  // one byte cycle; words are two calls, upper byte first
  task automatic busOp(input logic w, input logic [ADR_W-1:0] a, input logic [BUS_W-1:0] wd,
                       output logic [BUS_W-1:0] rd, output logic late);
    int n;
    @(posedge clk);
    {cyc, stb, we, sel} <= {3'h6 | 3'(w), 1'b1};
    adr <= a;
    dat <= wd;
    late = 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        late = 1'b0;
        break;
      end
    end
    rd = datIn;
    {cyc, stb, we} <= 3'h0;
  endtask
endmodule // dcpwm_bus_master

// File: dcpwm_channel.sv
// Purpose: shared constants and one pwm channel (waveform from duty value and step counter)
// Assumes: the step counter and the settings come from dcpwm_top on the same clock
// Notes:   the package sits in this file so it compiles before both modules

`timescale 1ns/1ns

package dcpwm_pkg;
  // widths
  localparam int DATA_W = 14;                   // duty value and counter width
  localparam int BUS_W  = 8;                    // peripheral data bus width
  localparam int ADR_W  = 3;                    // register address width
  // register byte offsets
  localparam logic [2:0] OFS_DUTY_A_HI = 3'h0;  // duty_reg_chan_a upper byte
  localparam logic [2:0] OFS_DUTY_A_LO = 3'h1;  // duty_reg_chan_a lower byte
  localparam logic [2:0] OFS_DUTY_B_HI = 3'h2;  // duty_reg_chan_b upper byte
  localparam logic [2:0] OFS_DUTY_B_LO = 3'h3;  // duty_reg_chan_b lower byte
  localparam logic [2:0] OFS_CTRL      = 3'h4;  // control byte
  localparam logic [2:0] OFS_CNT_HI    = 3'h5;  // pwm_step_counter upper byte
  localparam logic [2:0] OFS_CNT_LO    = 3'h6;  // pwm_step_counter lower byte
  // control byte fields
  localparam int CTRL_TEST = 7;                 // test bit, stored only
  localparam int CTRL_RUN  = 6;                 // counter run enable
  localparam int CTRL_OEB  = 3;                 // out_enable_chan_b
  localparam int CTRL_OEA  = 2;                 // out_enable_chan_a
  localparam int CTRL_POL  = 1;                 // output_polarity
  localparam int CTRL_CKS  = 0;                 // step_clock_select
  localparam logic [7:0] CTRL_RESERVED = 8'h30; // bits that always read as one
  localparam logic [7:0] CTRL_RESET    = 8'h30; // control reset value
  // duty register fields and reset values
  localparam int DUTY_CFS = 1;                  // carrier_select in duty_reg_chan_a
  localparam logic [13:0] DUTY_RESET = 14'h3fff;
  localparam logic [13:0] CNT_RESET  = 14'h0000;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
endpackage

module dcpwm_channel
  import dcpwm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // settings
  input  wire logic [DATA_W-1:0] dutyValue,
  input  wire logic              carrierSelect,
  input  wire logic              outputPolarity,
  input  wire logic              outEnable,
  // timing
  input  wire logic [DATA_W-1:0] stepCount,
  // pin
  output logic                   pwmOut,
  output logic                   pwmOutEn
);

  // bit reversal, used to spread the extra pulses evenly
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  logic [5:0] baseIdx6;           // base pulse index, 256-step carrier
  logic [7:0] baseIdx8;           // base pulse index, 64-step carrier
  logic [7:0] position;           // step inside the current base pulse
  logic       addPulse;           // this base pulse gets one extra step
  logic [8:0] threshold;          // active width of this base pulse
  logic       holdFixed;          // base duty zero: output held
  logic       active;             // inside the active part
  logic       rawWave;            // direct waveform, low while active
  logic       pwmOut_next;        // next pin level
  logic       pwmOut_reg;         // registered pin level
  logic       pwmOutEn_reg;       // registered pin enable

  // split the counter into base pulse index and position
  assign baseIdx6 = ~stepCount[13:8];
  assign baseIdx8 = ~stepCount[13:6];
  assign position = carrierSelect ? stepCount[7:0] : {2'b00, stepCount[5:0]};
  // fixed position table: reversed index below the low data bits
  assign addPulse = carrierSelect ? (rev8({baseIdx6, 2'b00}) < {2'b00, dutyValue[5:0]})
                                  : (rev8(baseIdx8) < dutyValue[7:0]);
  assign threshold = carrierSelect ? ({1'b0, dutyValue[13:6]} + {8'h00, addPulse})
                                   : ({3'b000, dutyValue[13:8]} + {8'h00, addPulse});
  assign holdFixed = carrierSelect ? (dutyValue[13:6] == 8'h00) : (dutyValue[13:8] == 6'h00);
  assign active    = {1'b0, position} < threshold;
  assign rawWave   = holdFixed ? 1'b0 : ~active;
  assign pwmOut_next = outEnable & (rawWave ^ outputPolarity);

  // pin registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pwmOut_reg   <= 1'b0;
      pwmOutEn_reg <= 1'b0;
    end else begin
      pwmOut_reg   <= pwmOut_next;
      pwmOutEn_reg <= outEnable;
    end
  end

  assign pwmOut   = pwmOut_reg;
  assign pwmOutEn = pwmOutEn_reg;

endmodule // dcpwm_channel

// File: dcpwm_checker.sv
// Purpose: port level assertions on dcpwm_top
// Assumes: single clock domain, synchronous active high reset
// Notes:   attached by bind below

`timescale 1ns/1ns

module dcpwm_checker
  import dcpwm_pkg::*;
(
  // clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // wishbone
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [0:0]       wb_sel_i,
  input wire logic [BUS_W-1:0] wb_dat_i,
  input wire logic [BUS_W-1:0] wb_dat_o,
  input wire logic             wb_ack_o,
  // pins
  input wire logic             pwmOutPinA,
  input wire logic             pwmOutPinAEn,
  input wire logic             pwmOutPinB,
  input wire logic             pwmOutPinBEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // request taken at this edge
  sequence takenReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence takenRead;
    takenReq ##0 !wb_we_i;
  endsequence
  sequence ctrlWrite;
    takenReq ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL);
  endsequence

  a_ack_after_req: assert property (takenReq |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_read_data_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without read");
  a_unmapped_reads_zero: assert property (takenRead ##0 wb_adr_i == 3'h7 |=> wb_dat_o == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  a_pin_a_gated: assert property (!pwmOutPinAEn |-> !pwmOutPinA)
    else $error("pin a high while disabled");
  a_pin_b_gated: assert property (!pwmOutPinBEn |-> !pwmOutPinB)
    else $error("pin b high while disabled");
  a_enable_follows_ctrl: assert property (ctrlWrite |-> ##2 (pwmOutPinAEn == $past(wb_dat_i[CTRL_OEA], 2)
    && pwmOutPinBEn == $past(wb_dat_i[CTRL_OEB], 2)))
    else $error("enable does not follow control");
endmodule // dcpwm_checker

bind dcpwm_top dcpwm_checker dcpwm_checker_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pwmOutPinA(pwmOutPinA), .pwmOutPinAEn(pwmOutPinAEn), .pwmOutPinB(pwmOutPinB),
  .pwmOutPinBEn(pwmOutPinBEn));

// File: dcpwm_tb_top.sv
// Purpose: self-checking bench for dcpwm_top
// Assumes: 250 MHz clock, reset held ten cycles
// Notes:   active width is counted over one full conversion cycle per setting

`timescale 1ns/1ns

module dcpwm_tb_top
  import dcpwm_pkg::*;
;
  logic             clk = 1'b0;  // system clock
  logic             rst = 1'b1;  // synchronous reset
  logic             cyc, stb, we, ack, pinA, pinAEn, pinB, pinBEn;
  logic [ADR_W-1:0] adr;
  logic [0:0]       sel;
  logic [BUS_W-1:0] datW, datR;
  int               badCount = 0;
  int               samplesChecked = 0;

  always #2 clk = ~clk;

  dcpwm_bus_master dcpwm_bus_master_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(datW), .datIn(datR), .ack(ack));
  dcpwm_top dcpwm_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .pwmOutPinA(pinA),
    .pwmOutPinAEn(pinAEn), .pwmOutPinB(pinB), .pwmOutPinBEn(pinBEn));

  // verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one byte cycle; a missing ack ends the run
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d, output logic [7:0] r);
    logic late;
    dcpwm_bus_master_i.busOp(w, a, d, r, late);
    if (late) begin
      badCount++;
      $display("[ERR] t=%0t ack=%h exp=%h", $time, 1'b0, 1'b1);
      endOfTest();
    end
  endtask

  task automatic wordWr(input logic [ADR_W-1:0] a, input logic [15:0] w);
    logic [7:0] r;
    bus(1'b1, a, w[15:8], r);
    bus(1'b1, a + 3'h1, w[7:0], r);
  endtask

  task automatic wordRd(input logic [ADR_W-1:0] a, output logic [15:0] w);
    bus(1'b0, a, 8'h00, w[15:8]);
    bus(1'b0, a + 3'h1, 8'h00, w[7:0]);
  endtask

  // active cycles expected in one conversion cycle
  function automatic logic [15:0] expAct(logic [13:0] d, logic carrier_select, logic step_clock_select);
    logic held;
    held = carrier_select ? (d[13:6] == 8'h00) : (d[13:8] == 6'h00);
    return (held ? 16'h4000 : {2'b00, d}) << step_clock_select;
  endfunction

  initial begin
    logic [15:0] w, aC, bC, eC;
    logic [13:0] dA, dB;
    logic [7:0]  ctl, rb;
    logic        carrier_select, os, step_clock_select;
    void'($urandom(32'h92e8a704));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wordRd(OFS_DUTY_A_HI, w);
    chk(w, 16'hffff);
    bus(1'b0, OFS_CTRL, 8'h00, rb);
    chk({8'h00, rb}, {8'h00, CTRL_RESET});
    bus(1'b0, 3'h7, 8'h00, rb);
    chk({8'h00, rb}, {8'h00, UNMAPPED_DATA});
    dA = 14'($urandom);
    wordWr(OFS_CNT_HI, {dA, 2'b11});
    wordRd(OFS_CNT_HI, w);
    chk(w, {dA, 2'b11});
    wordWr(OFS_DUTY_B_HI, 16'h5557);
    bus(1'b1, 3'h7, 8'h00, rb);
    wordRd(OFS_DUTY_B_HI, w);
    chk(w, 16'h5557);
    // carrier, polarity, step clock per pass; the last pass uses a held value
    for (int i = 0; i < 4; i++) begin
      carrier_select = 1'(4'b0101 >> i);
      os  = 1'(4'b0110 >> i);
      step_clock_select = 1'(4'b0100 >> i);
      dA  = carrier_select ? {8'(1 + $urandom % 254), 6'($urandom)} : {6'(1 + $urandom % 62), 8'($urandom)};
      dB  = carrier_select ? {8'(1 + $urandom % 254), 6'($urandom)} : {6'(1 + $urandom % 62), 8'($urandom)};
      if (i == 3) dA = 14'($urandom % 256);
      wordWr(OFS_DUTY_A_HI, {dA, carrier_select, 1'b1});
      wordWr(OFS_DUTY_B_HI, {dB, 2'b11});
      wordRd(OFS_DUTY_A_HI, w);
      chk(w, {dA, carrier_select, 1'b1});
      ctl = CTRL_RESERVED;
      ctl[CTRL_RUN] = 1'b1;
      ctl[CTRL_OEA] = 1'b1;
      ctl[CTRL_OEB] = (i != 3);
      ctl[CTRL_POL] = os;
      ctl[CTRL_CKS] = step_clock_select;
      bus(1'b1, OFS_CTRL, ctl, rb);
      repeat (4) @(posedge clk);
      {aC, bC, eC} = '0;
      repeat (32'h4000 << step_clock_select) begin
        @(posedge clk);
        aC += 16'(pinA === os);
        bC += 16'(pinB === os);
        eC += 16'(pinBEn === 1'b1);
      end
      chk(aC, expAct(dA, carrier_select, step_clock_select));
      if (i != 3) chk(bC, expAct(dB, carrier_select, step_clock_select));
      else chk(bC, os ? 16'h0000 : 16'h4000);
      chk(16'(pinAEn), 16'h0001);
      chk(eC, (i != 3) ? 16'(32'h4000 << step_clock_select) : 16'h0000);
    end
    endOfTest();
  end
endmodule // dcpwm_tb_top

// File: dcpwm_top.sv
// Purpose: dual channel pwm d/a converter with an 8-bit classic wishbone slave
// Assumes: single clock, synchronous active-high reset, byte wide bus
// Notes:   16-bit registers go through a byte staging register, upper byte first

`timescale 1ns/1ns

module dcpwm_top
  import dcpwm_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [0:0]       wb_sel_i,
  input  wire logic [BUS_W-1:0] wb_dat_i,
  output logic      [BUS_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  // channel a pin
  output logic                  pwmOutPinA,
  output logic                  pwmOutPinAEn,
  // channel b pin
  output logic                  pwmOutPinB,
  output logic                  pwmOutPinBEn
);

  // register map, one byte per offset
  //   offset 0: duty_reg_chan_a upper byte
  //   offset 1: duty_reg_chan_a lower byte
  //   offset 2: duty_reg_chan_b upper byte
  //   offset 3: duty_reg_chan_b lower byte
  //   offset 4: control byte
  //   offset 5: pwm_step_counter upper byte
  //   offset 6: pwm_step_counter lower byte
  //   offset 7: unmapped, reads zero, writes are dropped
  // word layout of the three 16-bit registers
  //   bits 15:2 hold the 14-bit data value
  //   duty a bit 1 is carrier_select, bit 0 reads one
  //   duty b bits 1:0 read one
  //   counter bits 1:0 read one
  // control byte layout
  //   bit 7 test, stored only, no effect on the waveform
  //   bit 6 counter run, the counter holds while clear
  //   bits 5:4 reserved, always read as one
  //   bit 3 out_enable_chan_b
  //   bit 2 out_enable_chan_a
  //   bit 1 output_polarity
  //   bit 0 step_clock_select, one gives a two clock step
  // bus timing
  //   a request is taken at the edge with cyc and stb high and ack low
  //   ack follows for exactly one cycle, then drops
  //   a write lands at the edge where its request is taken
  //   read data holds until the next read is taken
  // hazards for software
  //   a lower byte alone uses whatever the staging register last held
  //   an upper byte alone only refreshes the staging register
  //   a running counter reads consistently only through the upper-byte latch
  //   a counter write wins over a count in the same cycle

  // register state
  logic [DATA_W-1:0] dutyA_reg;        // duty_reg_chan_a data
  logic [DATA_W-1:0] dutyA_next;
  logic [DATA_W-1:0] dutyB_reg;        // duty_reg_chan_b data
  logic [DATA_W-1:0] dutyB_next;
  logic              carrier_reg;      // carrier_select
  logic              carrier_next;
  logic [7:0]        ctrl_reg;         // control byte
  logic [7:0]        ctrl_next;
  logic [7:0]        staging_reg;      // byte staging register
  logic [7:0]        staging_next;
  logic [DATA_W-1:0] count_reg;        // pwm_step_counter
  logic [DATA_W-1:0] count_next;
  logic              half_reg;         // step divider phase
  logic              ack_reg;          // bus acknowledge
  logic [7:0]        rdata_reg;        // read data register
  logic [7:0]        rdata_next;

  // bus decode
  logic              access;           // request taken this edge
  logic              wrEn;             // taken write with lane enabled
  logic              rdEn;             // taken read
  logic              selDutyAHi;       // address decodes
  logic              selDutyALo;
  logic              selDutyBHi;
  logic              selDutyBLo;
  logic              selCtrl;
  logic              selCntHi;
  logic              selCntLo;
  logic [15:0]       wordIn;           // staged word for lower-byte writes
  logic [15:0]       dutyAWord;        // register images as read
  logic [15:0]       dutyBWord;
  logic [15:0]       countWord;

  // timing
  logic              stepTick;         // one step elapsed
  logic              countRun;         // counter running

  // control fields
  logic              polarity;
  logic              stepClkSel;
  logic              out_enable_chan_a;
  logic              out_enable_chan_b;

  // control fields read straight from the control byte
  // a control write reaches the pins one edge after the edge where it is taken
  assign polarity   = ctrl_reg[CTRL_POL];
  assign stepClkSel = ctrl_reg[CTRL_CKS];
  assign out_enable_chan_a        = ctrl_reg[CTRL_OEA];
  assign out_enable_chan_b        = ctrl_reg[CTRL_OEB];
  assign countRun   = ctrl_reg[CTRL_RUN];

  // a request is taken once, answered on the next edge
  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wrEn   = access & wb_we_i & wb_sel_i[0];
  assign rdEn   = access & ~wb_we_i;

  // address decode
  assign selDutyAHi = (wb_adr_i == OFS_DUTY_A_HI);
  assign selDutyALo = (wb_adr_i == OFS_DUTY_A_LO);
  assign selDutyBHi = (wb_adr_i == OFS_DUTY_B_HI);
  assign selDutyBLo = (wb_adr_i == OFS_DUTY_B_LO);
  assign selCtrl    = (wb_adr_i == OFS_CTRL);
  assign selCntHi   = (wb_adr_i == OFS_CNT_HI);
  assign selCntLo   = (wb_adr_i == OFS_CNT_LO);

  // word images: unused low bits read as one
  assign dutyAWord = {dutyA_reg, carrier_reg, 1'b1};
  assign dutyBWord = {dutyB_reg, 2'b11};
  assign countWord = {count_reg, 2'b11};
  assign wordIn    = {staging_reg, wb_dat_i};

  // staging register: upper write stores, upper read latches lower
  always_comb begin
    staging_next = staging_reg;
    if (wrEn && (selDutyAHi || selDutyBHi || selCntHi)) begin
      staging_next = wb_dat_i;
    end else if (rdEn && selDutyAHi) begin
      staging_next = dutyAWord[7:0];
    end else if (rdEn && selDutyBHi) begin
      staging_next = dutyBWord[7:0];
    end else if (rdEn && selCntHi) begin
      staging_next = countWord[7:0];
    end
  end

  // duty registers load whole words on the lower byte write
  always_comb begin
    dutyA_next   = dutyA_reg;
    dutyB_next   = dutyB_reg;
    carrier_next = carrier_reg;
    if (wrEn && selDutyALo) begin
      dutyA_next   = wordIn[15:2];
      carrier_next = wordIn[DUTY_CFS];
    end
    if (wrEn && selDutyBLo) begin
      dutyB_next = wordIn[15:2];
    end
  end

  // control byte: reserved bits stay one
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrEn && selCtrl) begin
      ctrl_next = wb_dat_i | CTRL_RESERVED;
    end
  end

  // step counter: software word load wins over counting
  always_comb begin
    count_next = count_reg;
    if (wrEn && selCntLo) begin
      count_next = wordIn[15:2];
    end else if (countRun && stepTick) begin
      count_next = count_reg + 14'h0001;
    end
  end

  // step tick every clock or every second clock
  assign stepTick = ~stepClkSel | half_reg;

  // read mux, lower bytes of words come from the staging register
  always_comb begin
    rdata_next = UNMAPPED_DATA;
    if (selDutyAHi) begin
      rdata_next = dutyAWord[15:8];
    end else if (selDutyALo || selDutyBLo || selCntLo) begin
      rdata_next = staging_reg;
    end else if (selDutyBHi) begin
      rdata_next = dutyBWord[15:8];
    end else if (selCtrl) begin
      rdata_next = ctrl_reg;
    end else if (selCntHi) begin
      rdata_next = countWord[15:8];
    end
  end

  // register file and bus answer
  always_ff @(posedge clk) begin
    if (rst) begin
      dutyA_reg   <= DUTY_RESET;
      dutyB_reg   <= DUTY_RESET;
      carrier_reg <= 1'b1;
      ctrl_reg    <= CTRL_RESET;
      staging_reg <= 8'h00;
      ack_reg     <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      dutyA_reg   <= dutyA_next;
      dutyB_reg   <= dutyB_next;
      carrier_reg <= carrier_next;
      ctrl_reg    <= ctrl_next;
      staging_reg <= staging_next;
      ack_reg     <= access;
      rdata_reg   <= rdEn ? rdata_next : rdata_reg;
    end
  end

  // counter and step divider
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= CNT_RESET;
      half_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      half_reg  <= stepClkSel ? ~half_reg : 1'b0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // waveform summary, shared by both channels
  //   carrier_select one: 64 base pulses of 256 steps each
  //   carrier_select zero: 256 base pulses of 64 steps each
  //   the upper data bits give every base pulse its width
  //   the lower data bits pick the pulses that get one extra step
  //   extra pulses follow a bit-reversed order, so they spread evenly
  //   with low data bits kept zero the pattern repeats sooner
  //   a base width of zero holds the direct waveform low
  //   the direct waveform is low while a pulse is active
  //   output_polarity inverts the waveform before the enable gate
  //   a disabled channel drives zero and drops its enable
  //   a step lasts one clock, or two with step_clock_select set
  //   both channels share the counter, the carrier and the polarity
  //   pin levels trail the counter by one clock
  //   duty changes take effect at once, not at a cycle boundary
  //   software that wants glitch-free updates writes near a wrap

  // channel a, carries carrier select for both
  dcpwm_channel u_chan_a (
    .clk            (clk),
    .rst            (rst),
    .dutyValue      (dutyA_reg),
    .carrierSelect  (carrier_reg),
    .outputPolarity (polarity),
    .outEnable      (out_enable_chan_a),
    .stepCount      (count_reg),
    .pwmOut         (pwmOutPinA),
    .pwmOutEn       (pwmOutPinAEn)
  );

  // channel b
  dcpwm_channel u_chan_b (
    .clk            (clk),
    .rst            (rst),
    .dutyValue      (dutyB_reg),
    .carrierSelect  (carrier_reg),
    .outputPolarity (polarity),
    .outEnable      (out_enable_chan_b),
    .stepCount      (count_reg),
    .pwmOut         (pwmOutPinB),
    .pwmOutEn       (pwmOutPinBEn)
  );

endmodule // dcpwm_top
